// File: csds_pkg.sv
// ============================================================
// Shared constants and types for the clock source and divider system
package csds_pkg;

    // ============================================================
    // Synchroniser lanes, one for each asynchronous input
    localparam int NSYNC    = 9;
    localparam int IX_XTAL  = 0;
    localparam int IX_VLO   = 1;
    localparam int IX_RC_REFERENCE_OSCILLATOR  = 2;
    localparam int IX_DCO   = 3;
    localparam int IX_MOD   = 4;
    localparam int IX_PT0   = 5;
    localparam int IX_PT1   = 6;
    localparam int IX_PSA   = 7;
    localparam int IX_PSB   = 8;

    // ============================================================
    // Main clock source codes; the modulation oscillator has no code
    localparam logic [1:0] MSRC_XTAL = 2'h0;
    localparam logic [1:0] MSRC_VLO  = 2'h1;
    localparam logic [1:0] MSRC_RC_REFERENCE_OSCILLATOR = 2'h2;
    localparam logic [1:0] MSRC_DCO  = 2'h3;

    // Peripheral source select encodings
    localparam logic [1:0] TMR_PIN   = 2'h0;
    localparam logic [1:0] TMR_AUX   = 2'h1;
    localparam logic [1:0] TMR_SUB   = 2'h2;
    localparam logic [1:0] SER_PIN   = 2'h0;
    localparam logic [1:0] SER_MOD   = 2'h1;
    localparam logic [1:0] WDT_SUB   = 2'h0;
    localparam logic [1:0] WDT_AUX   = 2'h1;
    localparam logic [1:0] ADC_MOD   = 2'h0;
    localparam logic [1:0] ADC_AUX   = 2'h1;
    localparam logic [1:0] LCD_XTAL  = 2'h0;
    localparam logic [1:0] LCD_AUX   = 2'h1;
    localparam logic [1:0] RTC_NONE  = 2'h0;
    localparam logic [1:0] RTC_SUB   = 2'h1;
    localparam logic [1:0] RTC_XTAL  = 2'h2;

    // ============================================================
    // Register map (byte addresses)
    localparam int          AW         = 12;
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_PSEL  = 12'h004;
    localparam logic [11:0] ADDR_FLLT  = 12'h008;
    localparam logic [11:0] ADDR_STAT  = 12'h00c;

    typedef struct packed {
        logic       fll_en;
        logic       fll_ref_ext;
        logic       aux_rc_reference_oscillator;
        logic [1:0] sub_div;
        logic [2:0] main_div;
        logic [1:0] main_src;
    } csds_ctrl_t;

    typedef struct packed {
        logic [1:0] rtc;
        logic [1:0] display;
        logic [1:0] converter;
        logic [1:0] watchdog;
        logic [1:0] serial_b;
        logic [1:0] serial_a;
        logic [1:0] timer1;
        logic [1:0] timer0;
    } csds_psel_t;

    typedef struct packed {
        logic [1:0] main_active;
        logic [8:0] trim;
        logic       locked;
        logic       fault_live;
        logic       fault_sticky;
    } csds_stat_t;

    localparam csds_ctrl_t CTRL_RST = '{fll_en: 1'b1, fll_ref_ext: 1'b0, aux_rc_reference_oscillator: 1'b1,
                                        sub_div: 2'h0, main_div: 3'h0, main_src: MSRC_DCO};
    localparam csds_psel_t PSEL_RST = 16'h0000;
    localparam logic [9:0] FLLT_RST = 10'h1e8;
    localparam logic [9:0] LOCK_TOL = 10'h002;
    localparam logic [9:0] CNT_MAX  = 10'h3ff;
    localparam logic [8:0] TRIM_RST = 9'h100;
    localparam logic [8:0] TRIM_MAX = 9'h1ff;
    localparam logic [8:0] TRIM_MIN = 9'h000;

    // ============================================================
    // Timing
    localparam int          CLK_MHZ           = 25;
    localparam int          FAULT_TIME_US     = 200;
    localparam logic [15:0] FAULT_CYCLES_DFLT = 16'(FAULT_TIME_US * CLK_MHZ);
    localparam int          DIVCNT_W          = 7;

endpackage

// File: csds_divider.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Power-of-two divider: toggles after 2**div_log2 source half-periods
module csds_divider (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       src_lvl,
    input  wire logic [2:0] div_log2,
    output logic            clk_out
);

    typedef struct packed {
        logic                          prev;
        logic [csds_pkg::DIVCNT_W-1:0] cnt;
        logic                          out;
    } csds_div_t;

    csds_div_t                     s_r;
    csds_div_t                     s_nxt;
    logic [csds_pkg::DIVCNT_W-1:0] limit;

    always_comb begin
        s_nxt = s_r;
        limit = csds_pkg::DIVCNT_W'((8'h01 << div_log2) - 8'h01);
        s_nxt.prev = src_lvl;
        if (src_lvl != s_r.prev) begin
            // A ratio change mid-count applies at once: the running count is compared with the new limit
            if (s_r.cnt >= limit) begin
                s_nxt.cnt = '0;
                s_nxt.out = ~s_r.out;
            end else begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign clk_out = s_r.out;

endmodule
`default_nettype wire

// File: csds_top.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Main clock from crystal, low-power, reference or controlled oscillator, divide 1..128
// - Sub-main clock divides only the main clock by 1, 2, 4 or 8
// - Auxiliary clock comes from crystal or reference oscillator, at most 40 kHz
// - Controlled oscillator locks by a loop on internal or external 32 kHz reference
// - Failing crystal is replaced by the reference oscillator for all its users
// - Core, memories, checksum unit and ports all run on the main clock
// - Five sources: crystal, low-power, reference, controlled and modulation oscillators
module csds_top #(
    parameter logic [15:0] FAULT_CYCLES = csds_pkg::FAULT_CYCLES_DFLT
) (
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    // Oscillators and external clock pins, all asynchronous
    input  wire logic                    crystal_osc_clock,
    input  wire logic                    very_low_power_osc_clock,
    input  wire logic                    rc_reference_oscillator,
    input  wire logic                    digitally_controlled_oscillator,
    input  wire logic                    modulation_oscillator,
    input  wire logic                    timer0_pin_clock,
    input  wire logic                    timer1_pin_clock,
    input  wire logic                    serial_a_pin_clock,
    input  wire logic                    serial_b_pin_clock,
    // Pin function bits for crystal_input_pin and crystal_output_pin
    input  wire logic [1:0]              port4_function_select,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [csds_pkg::AW-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Clock outputs
    output logic                         main_clock,
    output logic                         sub_main_clock,
    output logic                         aux_clock,
    output logic                         timer0_clock,
    output logic                         timer1_clock,
    output logic                         serial_a_clock,
    output logic                         serial_b_clock,
    output logic                         watchdog_clock,
    output logic                         converter_clock,
    output logic                         display_clock,
    output logic                         rtc_counter_clock,
    output logic [8:0]                   dco_trim
);

    // ============================================================
    // State
    typedef struct packed {
        logic [csds_pkg::NSYNC-1:0] s1;
        logic [csds_pkg::NSYNC-1:0] s2;
        logic [csds_pkg::NSYNC-1:0] s3;
        logic [csds_pkg::NSYNC-1:0] lvl;
        logic [csds_pkg::NSYNC-1:0] prev;
        csds_pkg::csds_ctrl_t       ctrl;
        csds_pkg::csds_psel_t       psel_f;
        logic [9:0]                 fll_target;
        logic [9:0]                 dco_cnt;
        logic [8:0]                 trim;
        logic                       locked;
        logic                       ref_prev;
        logic [15:0]                fault_cnt;
        logic                       fault_live;
        logic                       fault_sticky;
        logic                       aux;
        logic                       t0;
        logic                       t1;
        logic                       sa;
        logic                       sb;
        logic                       wd;
        logic                       adc;
        logic                       lcd;
        logic                       rtc;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
    } csds_state_t;

    csds_state_t                s_r;
    csds_state_t                s_nxt;
    logic [csds_pkg::NSYNC-1:0] async_in;
    logic [csds_pkg::NSYNC-1:0] agree;
    logic                       main_div_out;
    logic                       sub_div_out;
    logic                       main_in;
    logic                       xtal_eff;
    logic                       ref_now;
    logic                       ref_rise;
    logic                       dco_rise;
    logic                       setup;
    logic                       access;
    csds_pkg::csds_stat_t       stat;
    csds_pkg::csds_stat_t       wstat;

    assign async_in[csds_pkg::IX_XTAL] = crystal_osc_clock;
    assign async_in[csds_pkg::IX_VLO]  = very_low_power_osc_clock;
    assign async_in[csds_pkg::IX_RC_REFERENCE_OSCILLATOR] = rc_reference_oscillator;
    assign async_in[csds_pkg::IX_DCO]  = digitally_controlled_oscillator;
    assign async_in[csds_pkg::IX_MOD]  = modulation_oscillator;
    assign async_in[csds_pkg::IX_PT0]  = timer0_pin_clock;
    assign async_in[csds_pkg::IX_PT1]  = timer1_pin_clock;
    assign async_in[csds_pkg::IX_PSA]  = serial_a_pin_clock;
    assign async_in[csds_pkg::IX_PSB]  = serial_b_pin_clock;

    // ============================================================
    // Dividers
    // main predivider
    csds_divider u_main_div (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .src_lvl  (main_in),
        .div_log2 (s_r.ctrl.main_div),
        .clk_out  (main_div_out)
    );

    csds_divider u_sub_div (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .src_lvl  (main_div_out),
        .div_log2 ({1'b0, s_r.ctrl.sub_div}),
        .clk_out  (sub_div_out)
    );

    // ============================================================
    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        wstat = csds_pkg::csds_stat_t'(pwdata[$bits(csds_pkg::csds_stat_t)-1:0]);

        // all nine asynchronous inputs synchronised
        // Level only moves once the second and third stages agree
        s_nxt.s1   = async_in;
        s_nxt.s2   = s_r.s1;
        s_nxt.s3   = s_r.s2;
        agree      = ~(s_r.s2 ^ s_r.s3);
        s_nxt.lvl  = (agree & s_r.s3) | (~agree & s_r.lvl);
        s_nxt.prev = s_r.lvl;

        // crystal pins configured
        // Without both pin functions the crystal is treated as absent
        if (port4_function_select != 2'h3) begin
            s_nxt.fault_cnt  = '0;
            s_nxt.fault_live = 1'b1;
        end else if (s_r.lvl[csds_pkg::IX_XTAL] != s_r.prev[csds_pkg::IX_XTAL]) begin
            s_nxt.fault_cnt  = '0;
            s_nxt.fault_live = 1'b0;
        end else if (s_r.fault_cnt >= FAULT_CYCLES - 16'h0001) begin
            s_nxt.fault_live = 1'b1;
        end else begin
            s_nxt.fault_cnt = s_r.fault_cnt + 16'h0001;
        end

        xtal_eff = s_r.fault_live ? s_r.lvl[csds_pkg::IX_RC_REFERENCE_OSCILLATOR] : s_r.lvl[csds_pkg::IX_XTAL];

        unique case (s_r.ctrl.main_src)
            csds_pkg::MSRC_XTAL: main_in = xtal_eff;
            csds_pkg::MSRC_VLO:  main_in = s_r.lvl[csds_pkg::IX_VLO];
            csds_pkg::MSRC_RC_REFERENCE_OSCILLATOR: main_in = s_r.lvl[csds_pkg::IX_RC_REFERENCE_OSCILLATOR];
            csds_pkg::MSRC_DCO:  main_in = s_r.lvl[csds_pkg::IX_DCO];
        endcase

        // aux from crystal or reference
        // Both sources are 32 kHz parts, so no divider is needed to stay under 40 kHz
        s_nxt.aux = s_r.ctrl.aux_rc_reference_oscillator ? s_r.lvl[csds_pkg::IX_RC_REFERENCE_OSCILLATOR] : xtal_eff;

        ref_now        = s_r.ctrl.fll_ref_ext ? xtal_eff : s_r.lvl[csds_pkg::IX_RC_REFERENCE_OSCILLATOR];
        s_nxt.ref_prev = ref_now;
        ref_rise       = ref_now & ~s_r.ref_prev;
        dco_rise       = s_r.lvl[csds_pkg::IX_DCO] & ~s_r.prev[csds_pkg::IX_DCO];
        if (!s_r.ctrl.fll_en) begin
            s_nxt.dco_cnt = '0;
            s_nxt.locked  = 1'b0;
        end else if (ref_rise) begin
            // One reference period counted: nudge trim toward the target count
            s_nxt.dco_cnt = {9'h000, dco_rise};
            if ({1'b0, s_r.dco_cnt} + {1'b0, csds_pkg::LOCK_TOL} < {1'b0, s_r.fll_target}) begin
                s_nxt.locked = 1'b0;
                if (s_r.trim != csds_pkg::TRIM_MAX) begin
                    s_nxt.trim = s_r.trim + 9'h001;
                end
            end else if ({1'b0, s_r.dco_cnt} >
                         {1'b0, s_r.fll_target} + {1'b0, csds_pkg::LOCK_TOL}) begin
                s_nxt.locked = 1'b0;
                if (s_r.trim != csds_pkg::TRIM_MIN) begin
                    s_nxt.trim = s_r.trim - 9'h001;
                end
            end else begin
                s_nxt.locked = 1'b1;
            end
        end else if (dco_rise && s_r.dco_cnt != csds_pkg::CNT_MAX) begin
            s_nxt.dco_cnt = s_r.dco_cnt + 10'h001;
        end

        unique case (s_r.psel_f.timer0)
            csds_pkg::TMR_PIN: s_nxt.t0 = s_r.lvl[csds_pkg::IX_PT0];
            csds_pkg::TMR_AUX: s_nxt.t0 = s_r.aux;
            default:           s_nxt.t0 = sub_div_out;
        endcase
        unique case (s_r.psel_f.timer1)
            csds_pkg::TMR_PIN: s_nxt.t1 = s_r.lvl[csds_pkg::IX_PT1];
            csds_pkg::TMR_AUX: s_nxt.t1 = s_r.aux;
            default:           s_nxt.t1 = sub_div_out;
        endcase
        unique case (s_r.psel_f.serial_a)
            csds_pkg::SER_PIN: s_nxt.sa = s_r.lvl[csds_pkg::IX_PSA];
            csds_pkg::SER_MOD: s_nxt.sa = s_r.lvl[csds_pkg::IX_MOD];
            default:           s_nxt.sa = sub_div_out;
        endcase
        unique case (s_r.psel_f.serial_b)
            csds_pkg::SER_PIN: s_nxt.sb = s_r.lvl[csds_pkg::IX_PSB];
            csds_pkg::SER_MOD: s_nxt.sb = s_r.lvl[csds_pkg::IX_MOD];
            default:           s_nxt.sb = sub_div_out;
        endcase
        unique case (s_r.psel_f.watchdog)
            csds_pkg::WDT_SUB: s_nxt.wd = sub_div_out;
            csds_pkg::WDT_AUX: s_nxt.wd = s_r.aux;
            default:           s_nxt.wd = s_r.lvl[csds_pkg::IX_VLO];
        endcase
        unique case (s_r.psel_f.converter)
            csds_pkg::ADC_MOD: s_nxt.adc = s_r.lvl[csds_pkg::IX_MOD];
            csds_pkg::ADC_AUX: s_nxt.adc = s_r.aux;
            default:           s_nxt.adc = sub_div_out;
        endcase
        unique case (s_r.psel_f.display)
            csds_pkg::LCD_XTAL: s_nxt.lcd = xtal_eff;
            csds_pkg::LCD_AUX:  s_nxt.lcd = s_r.aux;
            default:            s_nxt.lcd = s_r.lvl[csds_pkg::IX_VLO];
        endcase
        unique case (s_r.psel_f.rtc)
            csds_pkg::RTC_NONE: s_nxt.rtc = 1'b0;
            csds_pkg::RTC_SUB:  s_nxt.rtc = sub_div_out;
            csds_pkg::RTC_XTAL: s_nxt.rtc = xtal_eff;
            default:            s_nxt.rtc = s_r.lvl[csds_pkg::IX_VLO];
        endcase

        // ============================================================
        // APB slave: one access cycle, read data latched at setup
        stat.main_active  = s_r.ctrl.main_src;
        stat.trim         = s_r.trim;
        stat.locked       = s_r.locked;
        stat.fault_live   = s_r.fault_live;
        stat.fault_sticky = s_r.fault_sticky;
        setup  = psel & ~penable;
        access = psel & penable & s_r.pready;
        s_nxt.pready = 1'b0;
        if (setup) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = 1'b0;
            unique case (paddr)
                csds_pkg::ADDR_CTRL: s_nxt.prdata = 32'(s_r.ctrl);
                csds_pkg::ADDR_PSEL: s_nxt.prdata = 32'(s_r.psel_f);
                csds_pkg::ADDR_FLLT: s_nxt.prdata = 32'(s_r.fll_target);
                csds_pkg::ADDR_STAT: s_nxt.prdata = 32'(stat);
                default: begin
                    s_nxt.prdata  = 32'h0000_0000;
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end else if (access) begin
            s_nxt.pslverr = 1'b0;
            s_nxt.prdata  = 32'h0000_0000;
        end

        // Sticky fault: a new fault in the clearing cycle keeps the flag set
        s_nxt.fault_sticky = s_r.fault_sticky | s_nxt.fault_live;
        if (access && pwrite && !s_r.pslverr) begin
            unique case (paddr)
                csds_pkg::ADDR_CTRL: begin
                    s_nxt.ctrl = csds_pkg::csds_ctrl_t'(
                        pwdata[$bits(csds_pkg::csds_ctrl_t)-1:0]);
                end
                csds_pkg::ADDR_PSEL: begin
                    s_nxt.psel_f = csds_pkg::csds_psel_t'(
                        pwdata[$bits(csds_pkg::csds_psel_t)-1:0]);
                end
                csds_pkg::ADDR_FLLT: s_nxt.fll_target = pwdata[9:0];
                csds_pkg::ADDR_STAT: begin
                    s_nxt.fault_sticky = (s_r.fault_sticky & ~wstat.fault_sticky)
                                         | s_nxt.fault_live;
                end
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r            <= '0;
            s_r.ctrl       <= csds_pkg::CTRL_RST;
            s_r.psel_f     <= csds_pkg::PSEL_RST;
            s_r.fll_target <= csds_pkg::FLLT_RST;
            s_r.trim       <= csds_pkg::TRIM_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ============================================================
    // Outputs
    // main clock feeds core, memories, checksum unit and ports
    assign main_clock        = main_div_out;
    assign sub_main_clock    = sub_div_out;
    assign aux_clock         = s_r.aux;
    assign timer0_clock      = s_r.t0;
    assign timer1_clock      = s_r.t1;
    assign serial_a_clock    = s_r.sa;
    assign serial_b_clock    = s_r.sb;
    assign watchdog_clock    = s_r.wd;
    assign converter_clock   = s_r.adc;
    assign display_clock     = s_r.lcd;
    assign rtc_counter_clock = s_r.rtc;
    assign dco_trim          = s_r.trim;
    assign prdata            = s_r.prdata;
    assign pready            = s_r.pready;
    assign pslverr           = s_r.pslverr;

endmodule
`default_nettype wire

// File: csds_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Port checks on bus answers and clock relations
module csds_checker #(
    parameter logic [15:0] FAULT_CYCLES = 16'h0040
) (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        main_clock,
    input wire logic        sub_main_clock,
    input wire logic [8:0]  dco_trim
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    answer_next_a: assert property ((psel && !penable) |=> pready)
        else $error("no answer after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    pready_cause_a: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    unmapped_err_a: assert property (
        (psel && !penable && paddr > 12'h00c) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (
        (psel && !penable && paddr <= 12'h00c && paddr[1:0] == 2'h0) |=> !pslverr)
        else $error("mapped access refused");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("bus outputs not idle");
    // Sub-main only moves right after the main clock moved
    sub_follows_a: assert property (
        $changed(sub_main_clock) |-> $past(main_clock) != $past(main_clock, 2))
        else $error("sub-main moved on its own");
    trim_step_a: assert property (
        $changed(dco_trim) |-> dco_trim == $past(dco_trim) + 9'h1
        || dco_trim == $past(dco_trim) - 9'h1)
        else $error("trim jumped");
endmodule

bind csds_top csds_checker #(.FAULT_CYCLES(FAULT_CYCLES)) chk (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_clock(main_clock),
    .sub_main_clock(sub_main_clock), .dco_trim(dco_trim));
`default_nettype wire

// File: csds_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Oscillators and clock consumers; counts rising edges seen
module csds_partner (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        xtal_run,
    input  wire logic        clr,
    input  wire logic [10:0] seen,
    output logic [8:0]       osc,
    output int               cnt [11]
);
    logic [7:0]  cyc_r;
    logic [10:0] prev_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_r <= 8'h00;
            prev_r <= 11'h000;
            for (int i = 0; i < 11; i++) cnt[i] <= 0;
        end else begin
            cyc_r <= cyc_r + 8'h01;
            prev_r <= seen;
            for (int i = 0; i < 11; i++) cnt[i] <= clr ? 0 : cnt[i] + int'(seen[i] & ~prev_r[i]);
        end
    end
    // five oscillators and four pin clocks
    // Levels held 4+ cycles so the synchronisers never lose an edge
    assign osc = {{4{cyc_r[3]}}, cyc_r[3], cyc_r[2], cyc_r[4], cyc_r[5], xtal_run & cyc_r[3]};
endmodule
`default_nettype wire

// File: csds_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module csds_top_test;
    localparam int W = 2048;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, xtal_run = 1, clr = 0;
    logic [1:0] p4 = 2'h3;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, mc, sc, ac, t0, rc, t1, sa, sb, wd, cv, dc;
    logic [8:0] osc, tr;
    int cnt [11];
    int num_errors = 0, compares = 0, e;
    int per [4] = '{16, 64, 32, 8};
    int md [4] = '{1, 0, 2, 7};
    int sd [4] = '{3, 1, 2, 0};
    csds_top #(.FAULT_CYCLES(16'h0040)) uut (.mclk(mclk), .reset_n(reset_n),
        .crystal_osc_clock(osc[0]), .very_low_power_osc_clock(osc[1]),
        .rc_reference_oscillator(osc[2]), .digitally_controlled_oscillator(osc[3]),
        .modulation_oscillator(osc[4]), .timer0_pin_clock(osc[5]), .timer1_pin_clock(osc[6]),
        .serial_a_pin_clock(osc[7]), .serial_b_pin_clock(osc[8]), .port4_function_select(p4),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_clock(mc),
        .sub_main_clock(sc), .aux_clock(ac), .timer0_clock(t0), .timer1_clock(t1),
        .serial_a_clock(sa), .serial_b_clock(sb), .watchdog_clock(wd), .converter_clock(cv),
        .display_clock(dc), .rtc_counter_clock(rc), .dco_trim(tr));
    csds_partner far (.mclk(mclk), .reset_n(reset_n), .xtal_run(xtal_run), .clr(clr),
        .seen({sb, sa, t1, dc, cv, wd, rc, t0, ac, sc, mc}), .osc(osc), .cnt(cnt));
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic near(input int got, input int x);
        check(32'(got >= x - 1 && got <= x + 1), 32'h1);
    endtask
    // ============================================================
    // APB master: hold the request until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Settling time of 64 cycles is shorter than a divide-by-128 count, so a divider mid-count at the switch may still be counting
    task automatic measure;
        repeat (64) @(posedge mclk);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        repeat (W) @(posedge mclk);
    endtask
    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        print_verdict();
    end
    // ============================================================
    // Main sequence; crystal pin functions are set from time zero
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        apb(0, csds_pkg::ADDR_STAT, 0);
        check(32'(rd[13:3]), 32'h700);
        apb(0, csds_pkg::ADDR_CTRL, 0);
        check(rd, 32'h283);
        apb(0, csds_pkg::ADDR_PSEL, 0);
        check(rd, 32'h0);
        apb(0, csds_pkg::ADDR_FLLT, 0);
        check(rd, 32'h1e8);
        apb(1, 12'h010, 32'hffff);
        check(32'(er), 32'h1);
        check(rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            e = W / (per[i] << md[i]);
            apb(1, csds_pkg::ADDR_CTRL, 32'h280 | (sd[i] << 5) | (md[i] << 2) | i);
            apb(0, csds_pkg::ADDR_CTRL, 0);
            check(rd, 32'h280 | (sd[i] << 5) | (md[i] << 2) | i);
            measure();
            near(cnt[0], e);
            near(cnt[1], e >> sd[i]);
        end
        measure();
        near(cnt[3], W / 16);
        check(cnt[4], 0);
        near(cnt[5], W / 1024);
        near(cnt[6], W / 16);
        near(cnt[7], W / 16);
        near(cnt[8], W / 16);
        near(cnt[9], W / 16);
        near(cnt[10], W / 16);
        apb(1, csds_pkg::ADDR_PSEL, 32'he5d9);
        measure();
        near(cnt[2], W / 32);
        near(cnt[3], W / 32);
        near(cnt[4], W / 64);
        near(cnt[5], W / 32);
        near(cnt[6], W / 32);
        near(cnt[7], W / 64);
        near(cnt[8], W / 1024);
        near(cnt[9], W / 16);
        near(cnt[10], W / 1024);
        apb(1, csds_pkg::ADDR_CTRL, 32'h203);
        measure();
        near(cnt[2], W / 16);
        xtal_run <= 1'b0;
        repeat (72) @(posedge mclk);
        apb(0, csds_pkg::ADDR_STAT, 0);
        check(32'(rd[1]), 32'h1);
        measure();
        near(cnt[2], W / 32);
        xtal_run <= 1'b1;
        repeat (32) @(posedge mclk);
        apb(1, csds_pkg::ADDR_STAT, 32'h1);
        apb(0, csds_pkg::ADDR_STAT, 0);
        check(32'(rd[1:0]), 32'h0);
        check(32'(rd[13:2]), 32'hffe);
        check(32'(tr), 32'h1ff);
        p4 <= 2'h1;
        apb(0, csds_pkg::ADDR_STAT, 0);
        check(32'(rd[1]), 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
